//--- hw/tip_port.sv
`timescale 1ns/100ps
module tip_port #(
  parameter int unsigned FIFO_DEPTH = tip_pkg::FIFO_DEPTH
) (
  // clock, reset, enable
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  // macrocell power-down level, asynchronous
  input wire logic trace_pwrdn_in,
  // write-back stage instruction
  input wire logic wb_instr_valid_in,
  input wire logic [tip_pkg::ADDR_W-1:0] wb_instr_pc_in,
  input wire tip_pkg::tip_isa_t wb_isa_in,
  input wire logic wb_data_instr_in,
  input wire logic wb_bounce_in,
  input wire logic wb_context_in,
  input wire logic wb_indirect_in,
  input wire logic wb_cond_fail_in,
  // write-back stage branch phantom
  input wire logic wb_phantom_valid_in,
  input wire logic [tip_pkg::ADDR_W-1:0] wb_phantom_ret_in,
  input wire logic wb_phantom_cond_fail_in,
  // exception taken by the core
  input wire logic exc_take_in,
  input wire tip_pkg::tip_exc_kind_t exc_kind_in,
  input wire logic exc_slot_kill_in,
  input wire logic exc_dabort_in,
  input wire logic exc_cancel_in,
  // address stage data transfer
  input wire logic add_valid_in,
  input wire logic [tip_pkg::ADDR_W-1:0] add_addr_in,
  input wire logic [tip_pkg::DCTL_HI_W-1:0] add_ctrl_in,
  output logic add_ready_out,
  // macrocell hold on the data stream
  input wire logic trace_hold_in,
  // instruction trace outputs
  output logic [tip_pkg::CTL_W-1:0] instr_trace_ctrl_out,
  output logic [tip_pkg::ADDR_W-1:0] instr_trace_addr_out,
  output logic [tip_pkg::ADDR_W-1:0] mispredict_return_addr_out,
  // data address trace outputs
  output logic [tip_pkg::CTL_W-1:0] data_trace_ctrl_out,
  output logic [tip_pkg::ADDR_W-1:tip_pkg::DADDR_LSB] data_trace_addr_out
);
  localparam int unsigned ENTRY_W =
    tip_pkg::DADDR_W + tip_pkg::DCTL_HI_W + tip_pkg::SLOT_W;

  typedef struct packed {
    logic pwr_meta;
    logic pwr_sync;
    tip_pkg::tip_exc_state_t exc_state;
    logic [2:0] exc_code;
    logic exc_kill;
    logic exc_abort;
    logic exc_cancel;
    logic [tip_pkg::SLOT_W-1:0] slot;
    logic [tip_pkg::CTL_W-1:0] ia_ctrl;
    logic [tip_pkg::ADDR_W-1:0] ia_addr;
    logic [tip_pkg::ADDR_W-1:0] ia_ret;
    logic [tip_pkg::CTL_W-1:0] da_ctrl;
    logic [tip_pkg::DADDR_W-1:0] da_addr;
  } tip_port_state_t;

  tip_port_state_t st;
  tip_port_state_t next_st;

  logic fifo_ready;
  logic fifo_valid;
  logic [ENTRY_W-1:0] fifo_data;
  logic fifo_pop;
  logic push;

  assign push = add_valid_in && fifo_ready;
  assign fifo_pop = fifo_valid && !trace_hold_in;

  // address stage entries queue here; core stalls on a full queue
  tip_fifo #(.WIDTH(ENTRY_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .ce_in(ce_in),
    .in_valid_in(add_valid_in),
    .in_data_in({add_addr_in[tip_pkg::ADDR_W-1:tip_pkg::DADDR_LSB],
                 add_ctrl_in, st.slot}),
    .in_ready_out(fifo_ready),
    .out_valid_out(fifo_valid),
    .out_data_out(fifo_data),
    .out_ready_in(!trace_hold_in)
  );

  // exception code from the kind reported by the core
  function automatic logic [2:0] exc_code_of(tip_pkg::tip_exc_kind_t k);
    logic [2:0] c;
    c = tip_pkg::EXC_CODE_OTHER;
    case (k)
      tip_pkg::TIP_EXK_IRQ: c = tip_pkg::EXC_CODE_IRQ;
      tip_pkg::TIP_EXK_FIQ: c = tip_pkg::EXC_CODE_FIQ;
      tip_pkg::TIP_EXK_BYTECODE: c = tip_pkg::EXC_CODE_BYTECODE;
      tip_pkg::TIP_EXK_IMPRECISE: c = tip_pkg::EXC_CODE_IMPRECISE;
      default: c = tip_pkg::EXC_CODE_OTHER;
    endcase
    return c;
  endfunction

  // all next-state logic; ce low freezes everything
  always_comb begin
    logic alive;
    logic inst;
    logic bp;
    logic vec;
    logic [tip_pkg::DCTL_HI_W-1:0] dhi;
    logic [tip_pkg::CTL_W-1:0] c;
    alive = 1'b0;
    inst = 1'b0;
    bp = 1'b0;
    vec = 1'b0;
    dhi = '0;
    c = '0;
    next_st = st;
    if (ce_in) begin
      // power-down level crosses in through two flops
      next_st.pwr_meta = trace_pwrdn_in;
      next_st.pwr_sync = st.pwr_meta;
      // exception tracker: held from take until vector instruction
      case (st.exc_state)
        tip_pkg::TIP_EXC_IDLE: begin
          if (exc_take_in) begin
            next_st.exc_state = tip_pkg::TIP_EXC_HELD;
          end
        end
        tip_pkg::TIP_EXC_HELD: begin
          if (!exc_take_in && wb_instr_valid_in) begin
            next_st.exc_state = tip_pkg::TIP_EXC_IDLE;
          end
        end
        default: next_st.exc_state = tip_pkg::TIP_EXC_IDLE;
      endcase
      if (exc_take_in) begin
        next_st.exc_code = exc_code_of(exc_kind_in);
        next_st.exc_kill = exc_slot_kill_in;
        next_st.exc_abort = exc_dabort_in;
        next_st.exc_cancel = exc_cancel_in;
      end
      vec = exc_take_in || st.exc_state == tip_pkg::TIP_EXC_HELD;
      // a quiet macrocell sees no valid cycles at all
      alive = (wb_instr_valid_in || wb_phantom_valid_in) && !st.pwr_sync;
      inst = wb_instr_valid_in && alive;
      bp = wb_phantom_valid_in && alive;
      // exception fields, unqualified by interface valid
      if (vec) begin
        c[tip_pkg::IA_EXC_VEC] = 1'b1;
        c[tip_pkg::IA_SLOT_KILL] = next_st.exc_kill;
        c[tip_pkg::IA_DABORT] = next_st.exc_abort;
        c[tip_pkg::IA_CANCEL] = next_st.exc_cancel;
        c[tip_pkg::IA_EXC_HI:tip_pkg::IA_EXC_LO] = next_st.exc_code;
      end
      // flags qualified by instruction, phantom or interface valid, and the valid bits
      c[tip_pkg::IA_DATA] = inst && wb_data_instr_in;
      c[tip_pkg::IA_BOUNCE] = inst && wb_data_instr_in && wb_bounce_in;
      c[tip_pkg::IA_CONTEXT] = inst && wb_context_in;
      c[tip_pkg::IA_INDBR] = inst && wb_indirect_in;
      c[tip_pkg::IA_CCFAIL] = inst && wb_cond_fail_in;
      c[tip_pkg::IA_BP_CCFAIL] = bp && wb_phantom_cond_fail_in;
      c[tip_pkg::IA_BYTECODE] = alive &&
        wb_isa_in == tip_pkg::TIP_ISA_BYTECODE;
      c[tip_pkg::IA_COMPACT] = alive &&
        wb_isa_in == tip_pkg::TIP_ISA_COMPACT;
      c[tip_pkg::IA_BP_VALID] = bp;
      c[tip_pkg::IA_INSTR_VALID] = inst;
      c[tip_pkg::IA_VALID] = alive;
      next_st.ia_ctrl = c;
      // reported address carries the pipeline offset of its set
      if (alive) begin
        case (wb_isa_in)
          tip_pkg::TIP_ISA_COMPACT:
            next_st.ia_addr = wb_instr_pc_in + tip_pkg::PC_OFS_COMPACT;
          tip_pkg::TIP_ISA_BYTECODE:
            next_st.ia_addr = wb_instr_pc_in + tip_pkg::PC_OFS_BYTECODE;
          default:
            next_st.ia_addr = wb_instr_pc_in + tip_pkg::PC_OFS_PRIMARY;
        endcase
      end
      if (bp) begin
        next_st.ia_ret = wb_phantom_ret_in;
      end
      // slot numbers run 1..3, never the idle code
      if (push) begin
        if (st.slot == tip_pkg::SLOT_LAST) begin
          next_st.slot = tip_pkg::SLOT_FIRST;
        end else begin
          next_st.slot = st.slot + 2'h1;
        end
      end
      // drain one queued transfer a cycle unless the macrocell holds
      next_st.da_ctrl = '0;
      next_st.da_addr = '0;
      if (fifo_pop) begin
        dhi = fifo_data[tip_pkg::DCTL_HI_W+tip_pkg::SLOT_W-1:tip_pkg::SLOT_W];
        next_st.da_ctrl = {dhi, fifo_data[tip_pkg::DA_SLOT_HI:0]};
        // transfers to coprocessor registers carry no address
        if (!dhi[tip_pkg::DA_COPROC_REGISTER_TRANSFER_IN]) begin
          next_st.da_addr = fifo_data[ENTRY_W-1:ENTRY_W-tip_pkg::DADDR_W];
        end
      end
    end
  end

  // single state register, all outputs but add_ready_out taken from it
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st <= '{pwr_meta: 1'b1, pwr_sync: 1'b1,
              exc_state: tip_pkg::TIP_EXC_IDLE, exc_code: '0,
              exc_kill: 1'b0, exc_abort: 1'b0, exc_cancel: 1'b0,
              slot: tip_pkg::SLOT_FIRST, ia_ctrl: '0, ia_addr: '0,
              ia_ret: '0, da_ctrl: '0, da_addr: '0};
    end else begin
      st <= next_st;
    end
  end

  assign instr_trace_ctrl_out = st.ia_ctrl;
  assign instr_trace_addr_out = st.ia_addr;
  assign mispredict_return_addr_out = st.ia_ret;
  assign data_trace_ctrl_out = st.da_ctrl;
  assign data_trace_addr_out = st.da_addr;
  assign add_ready_out = fifo_ready;

  // checks on the trace bundle
  sequence s_exc_vector;
    ce_in && st.exc_state == tip_pkg::TIP_EXC_HELD &&
      wb_instr_valid_in && !exc_take_in;
  endsequence

  sequence s_quiet;
    ce_in && !exc_take_in;
  endsequence

  property p_exc_drops;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      s_exc_vector ##1 s_quiet |-> st.ia_ctrl[tip_pkg::IA_EXC_VEC]
        ##1 !st.ia_ctrl[tip_pkg::IA_EXC_VEC];
  endproperty

  exc_vector_hold_a: assert property (p_exc_drops)
    else $error("exception flag not cleared after vector instruction");

  exc_take_sets_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    ce_in && exc_take_in && exc_kind_in == tip_pkg::TIP_EXK_FIQ |=>
      st.ia_ctrl[tip_pkg::IA_EXC_VEC] &&
      st.ia_ctrl[tip_pkg::IA_EXC_HI:tip_pkg::IA_EXC_LO] == 3'h5)
    else $error("fast interrupt code wrong");

  exc_fields_qual_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    (st.ia_ctrl[tip_pkg::IA_SLOT_KILL] || st.ia_ctrl[tip_pkg::IA_DABORT] ||
     st.ia_ctrl[tip_pkg::IA_CANCEL]) |-> st.ia_ctrl[tip_pkg::IA_EXC_VEC])
    else $error("exception detail without exception flag");

  primary_offset_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    ce_in && wb_instr_valid_in && !st.pwr_sync &&
      wb_isa_in == tip_pkg::TIP_ISA_PRIMARY |=>
      st.ia_addr == $past(wb_instr_pc_in) + 32'h0000_0008)
    else $error("primary address offset wrong");

  powered_down_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    ce_in && st.pwr_sync |=> !st.ia_ctrl[tip_pkg::IA_VALID])
    else $error("interface valid while macrocell powered down");

  phantom_alone_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    ce_in && wb_phantom_valid_in && !wb_instr_valid_in && !st.pwr_sync |=>
      st.ia_ctrl[tip_pkg::IA_BP_VALID] && st.ia_ctrl[tip_pkg::IA_VALID] &&
      !st.ia_ctrl[tip_pkg::IA_INSTR_VALID] &&
      st.ia_ret == $past(wb_phantom_ret_in))
    else $error("lone phantom not reported");

  bounce_qual_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    st.ia_ctrl[tip_pkg::IA_BOUNCE] |-> st.ia_ctrl[tip_pkg::IA_DATA] &&
      st.ia_ctrl[tip_pkg::IA_INSTR_VALID])
    else $error("bounce without data instruction");

  data_addr_qual_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    st.da_ctrl[tip_pkg::DA_SLOT_HI:0] == 2'h0 || st.da_ctrl[tip_pkg::DA_COPROC_REGISTER_TRANSFER]
      |-> st.da_addr == '0)
    else $error("data address shown without qualifier");

  slot_never_idle_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    ce_in && push |=> st.slot != 2'h0 && st.slot != $past(st.slot))
    else $error("slot number idle or not advanced");
endmodule

//--- include/tip_pkg.sv
package tip_pkg;
  // widths of the port buses
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned CTL_W = 18;
  localparam int unsigned DADDR_LSB = 3;
  localparam int unsigned DADDR_W = ADDR_W - DADDR_LSB;
  localparam int unsigned DCTL_HI_W = 16;
  localparam int unsigned SLOT_W = 2;
  localparam int unsigned FIFO_DEPTH = 16;

  // instruction control bundle field positions
  localparam int unsigned IA_SLOT_KILL = 17;
  localparam int unsigned IA_DABORT = 16;
  localparam int unsigned IA_CANCEL = 15;
  localparam int unsigned IA_EXC_HI = 14;
  localparam int unsigned IA_EXC_LO = 12;
  localparam int unsigned IA_EXC_VEC = 11;
  localparam int unsigned IA_BOUNCE = 10;
  localparam int unsigned IA_DATA = 9;
  localparam int unsigned IA_CONTEXT = 8;
  localparam int unsigned IA_INDBR = 7;
  localparam int unsigned IA_BP_CCFAIL = 6;
  localparam int unsigned IA_CCFAIL = 5;
  localparam int unsigned IA_BYTECODE = 4;
  localparam int unsigned IA_COMPACT = 3;
  localparam int unsigned IA_BP_VALID = 2;
  localparam int unsigned IA_INSTR_VALID = 1;
  localparam int unsigned IA_VALID = 0;

  // data control bundle: upper bits [17:2] come from the core, slot in [1:0]
  localparam int unsigned DA_HI_LSB = 2;
  localparam int unsigned DA_SLOT_HI = 1;
  localparam int unsigned DA_COPROC_REGISTER_TRANSFER = 15;
  localparam int unsigned DA_COPROC_REGISTER_TRANSFER_IN = DA_COPROC_REGISTER_TRANSFER - DA_HI_LSB;

  // slot numbering, zero means no transfer
  localparam logic [1:0] SLOT_IDLE = 2'h0;
  localparam logic [1:0] SLOT_FIRST = 2'h1;
  localparam logic [1:0] SLOT_LAST = 2'h3;

  // pipeline offsets of the reported address per instruction set
  localparam logic [31:0] PC_OFS_PRIMARY = 32'h0000_0008;
  localparam logic [31:0] PC_OFS_COMPACT = 32'h0000_0004;
  localparam logic [31:0] PC_OFS_BYTECODE = 32'h0000_0000;

  // exception type codes
  localparam logic [2:0] EXC_CODE_OTHER = 3'h0;
  localparam logic [2:0] EXC_CODE_IRQ = 3'h1;
  localparam logic [2:0] EXC_CODE_FIQ = 3'h5;
  localparam logic [2:0] EXC_CODE_BYTECODE = 3'h4;
  localparam logic [2:0] EXC_CODE_IMPRECISE = 3'h6;

  typedef enum logic [1:0] {
    TIP_ISA_PRIMARY = 2'h0,
    TIP_ISA_COMPACT = 2'h1,
    TIP_ISA_BYTECODE = 2'h2
  } tip_isa_t;

  typedef enum logic [2:0] {
    TIP_EXK_OTHER = 3'h0,
    TIP_EXK_IRQ = 3'h1,
    TIP_EXK_FIQ = 3'h2,
    TIP_EXK_BYTECODE = 3'h3,
    TIP_EXK_IMPRECISE = 3'h4
  } tip_exc_kind_t;

  typedef enum logic [1:0] {
    TIP_EXC_IDLE = 2'h1,
    TIP_EXC_HELD = 2'h2
  } tip_exc_state_t;
endpackage

//--- hw/tip_mem.sv
`timescale 1ns/100ps
module tip_mem #(
  parameter int unsigned WIDTH = 47,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW = 4
) (
  // clock, reset, enable
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  // write port
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [WIDTH-1:0] wdata_in,
  // registered read port
  input wire logic [AW-1:0] raddr_in,
  output logic [WIDTH-1:0] rdata_out
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] cells;
    logic [WIDTH-1:0] rdata;
  } tip_mem_state_t;

  tip_mem_state_t st;
  tip_mem_state_t next_st;

  // write-first: a word written to the read address is seen at once
  always_comb begin
    next_st = st;
    if (ce_in) begin
      if (we_in) begin
        next_st.cells[waddr_in] = wdata_in;
      end
      if (we_in && waddr_in == raddr_in) begin
        next_st.rdata = wdata_in;
      end else begin
        next_st.rdata = st.cells[raddr_in];
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_out = st.rdata;
endmodule

//--- hw/tip_fifo.sv
`timescale 1ns/100ps
module tip_fifo #(
  parameter int unsigned WIDTH = 47,
  parameter int unsigned DEPTH = 16
) (
  // clock, reset, enable
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  // filling side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // draining side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  // depth must be a power of two so the pointers wrap by themselves
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = AW + 1;

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic room;
    logic filled;
  } tip_fifo_state_t;

  tip_fifo_state_t st;
  tip_fifo_state_t next_st;
  logic push;
  logic pop;

  // pointer and flag update, flags kept in flops for clean ports
  always_comb begin
    next_st = st;
    push = in_valid_in && st.room;
    pop = st.filled && out_ready_in;
    if (ce_in) begin
      if (push) begin
        next_st.wr_ptr = st.wr_ptr + AW'(1);
      end
      if (pop) begin
        next_st.rd_ptr = st.rd_ptr + AW'(1);
      end
      next_st.count = st.count + CW'(push) - CW'(pop);
      next_st.room = next_st.count != CW'(DEPTH);
      next_st.filled = next_st.count != CW'(0);
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st <= '{wr_ptr: '0, rd_ptr: '0, count: '0, room: 1'b1, filled: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // storage reads ahead at the next head so data match the flags
  tip_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .ce_in(ce_in && (push || pop || !st.filled)),
    .we_in(push),
    .waddr_in(st.wr_ptr),
    .wdata_in(in_data_in),
    .raddr_in(next_st.rd_ptr),
    .rdata_out(out_data_out)
  );

  assign in_ready_out = st.room;
  assign out_valid_out = st.filled;
endmodule

//--- testbench/tip_tmc_model.sv
`timescale 1ns/100ps
// behavioural trace macrocell: captures the port, rebuilds phantom addresses
module tip_tmc_model (
  // port from the core
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic [17:0] instr_trace_ctrl_in,
  input wire logic [31:0] instr_trace_addr_in,
  input wire logic [31:0] mispredict_return_addr_in,
  // rebuilt branch addresses
  output logic [31:0] taken_branch_addr_out,
  output logic [31:0] untaken_branch_addr_out
);
  logic [17:0] ctl;
  logic [31:0] ia;
  logic [31:0] ret;
  logic [31:0] isize;
  // every input registered on arrival, before any decode
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctl <= '0;
      ia <= '0;
      ret <= '0;
    end else begin
      ctl <= instr_trace_ctrl_in;
      ia <= instr_trace_addr_in; // zero address before reset is fine
      ret <= mispredict_return_addr_in;
    end
  end
  // bytecode size taken as one byte, a limitation of this model
  always_comb begin
    isize = ctl[4] ? 32'h0000_0001 : (ctl[3] ? 32'h0000_0002 : 32'h0000_0004);
    taken_branch_addr_out = ret - isize;
    untaken_branch_addr_out = ia - isize;
    if (!(ctl[0] && ctl[2])) begin
      taken_branch_addr_out = '0; // unqualified fields ignored
      untaken_branch_addr_out = '0;
    end
  end
endmodule

//--- testbench/tb_tip_port.sv
`timescale 1ns/100ps
module tb_tip_port;
  logic clk = 0, rst_n = 0, pwrdn = 0, iv = 0, dinst = 0, bnc = 0, ctx = 0;
  logic ind = 0, ccf = 0, pv = 0, pccf = 0, xt = 0, xsk = 0, xda = 0, xc = 0;
  logic av = 0, hold = 0, ardy;
  logic [31:0] pc = '0, ret = '0, aaddr = '0, iaddr, raddr, bp_t, bp_n;
  logic [15:0] actl = '0;
  logic [17:0] ictl, dctl;
  logic [31:3] daddr;
  tip_pkg::tip_isa_t isa = tip_pkg::TIP_ISA_PRIMARY;
  tip_pkg::tip_exc_kind_t xk = tip_pkg::TIP_EXK_OTHER;
  int bad_count = 0, compares = 0;
  // free-running core clock, 40 ns period
  always #20 clk = ~clk;
  tip_port u_dut (.core_clk_in(clk), .reset_n_in(rst_n), .ce_in(1'b1),
    .trace_pwrdn_in(pwrdn), .wb_instr_valid_in(iv), .wb_instr_pc_in(pc),
    .wb_isa_in(isa), .wb_data_instr_in(dinst), .wb_bounce_in(bnc),
    .wb_context_in(ctx), .wb_indirect_in(ind), .wb_cond_fail_in(ccf),
    .wb_phantom_valid_in(pv), .wb_phantom_ret_in(ret),
    .wb_phantom_cond_fail_in(pccf), .exc_take_in(xt), .exc_kind_in(xk),
    .exc_slot_kill_in(xsk), .exc_dabort_in(xda), .exc_cancel_in(xc),
    .add_valid_in(av), .add_addr_in(aaddr), .add_ctrl_in(actl),
    .add_ready_out(ardy), .trace_hold_in(hold),
    .instr_trace_ctrl_out(ictl), .instr_trace_addr_out(iaddr),
    .mispredict_return_addr_out(raddr), .data_trace_ctrl_out(dctl),
    .data_trace_addr_out(daddr));
  tip_tmc_model u_tmc (.core_clk_in(clk), .reset_n_in(rst_n),
    .instr_trace_ctrl_in(ictl), .instr_trace_addr_in(iaddr),
    .mispredict_return_addr_in(raddr), .taken_branch_addr_out(bp_t),
    .untaken_branch_addr_out(bp_n));
  task automatic check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // inputs always move one nanosecond after the edge
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // one instruction per set, back to back, with every per-instruction flag
  task automatic test_instr();
    logic [31:0] ofs [3] = '{32'h0000_0008, 32'h0000_0004, 32'h0000_0000};
    for (int i = 0; i < 3; i++) begin
      iv = 1;
      pc = 32'h0000_1000 + 32'(i * 16);
      isa = tip_pkg::tip_isa_t'(i);
      dinst = (i != 1);
      bnc = (i == 2);
      ctx = (i == 1);
      ind = (i == 2);
      ccf = (i == 0);
      tick();
      check("ictl", {21'h0, ictl[10:0]}, {21'h0, bnc, dinst, ctx, ind, 1'b0,
        ccf, i == 2, i == 1, 3'b011});
      check("iaddr", iaddr, pc + ofs[i]);
    end
    iv = 0;
    tick();
    check("idle instr", {31'h0, ictl[1]}, 32'h0000_0000);
    $display("test instr done");
  endtask
  // a phantom with no normal instruction, then the macrocell rebuild
  task automatic test_phantom();
    pv = 1;
    pccf = 1;
    ret = 32'h0000_2004;
    isa = tip_pkg::TIP_ISA_COMPACT;
    tick();
    pv = 0;
    check("ictl ph", {25'h0, ictl[6:0]}, 32'h0000_004d);
    check("raddr", raddr, 32'h0000_2004);
    tick();
    check("bp taken", bp_t, 32'h0000_2002);
    check("bp untaken", bp_n, 32'h0000_1022);
    $display("test phantom done");
  endtask
  // every exception kind, held until the vector instruction
  task automatic test_exc();
    logic [2:0] code [5] = '{3'h0, 3'h1, 3'h5, 3'h4, 3'h6};
    for (int k = 0; k < 5; k++) begin
      xt = 1;
      xk = tip_pkg::tip_exc_kind_t'(k);
      {xc, xda, xsk} = 3'(k + 1);
      tick();
      xt = 0;
      for (int h = 0; h < 2; h++) begin
        check("exc", {25'h0, ictl[17:11]}, {25'h0, xsk, xda, xc, code[k],
          1'b1});
        iv = (h == 1);
        tick();
      end
      iv = 0;
      check("exc vec", {30'h0, ictl[11], ictl[1]}, 32'h0000_0003);
      tick();
      check("exc end", {31'h0, ictl[11]}, 32'h0000_0000);
    end
    $display("test exc done");
  endtask
  // fill the queue while held, then drain with the macrocell stalling
  task automatic test_data();
    int n = 0, k = 0;
    logic acc;
    hold = 1;
    for (int g = 0; g < 20; g++) begin
      av = 1;
      aaddr = 32'h0000_4005 + 32'(n * 8);
      actl = (n == 3) ? 16'h2000 : 16'(n);
      acc = ardy;
      tick();
      check("held slot", {30'h0, dctl[1:0]}, 32'h0000_0000);
      if (acc) n++;
    end
    av = 0;
    check("queued", 32'(n), 32'(tip_pkg::FIFO_DEPTH));
    check("full ready", {31'h0, ardy}, 32'h0000_0000);
    for (int c = 0; c < 80; c++) begin
      hold = c[1];
      tick();
      if (dctl[1:0] != 2'h0) begin
        check("slot", {30'h0, dctl[1:0]}, 32'(k % 3 + 1));
        check("dctl", {16'h0, dctl[17:2]}, (k == 3) ? 32'h0000_2000 :
          32'(k));
        check("daddr", {3'h0, daddr}, (k == 3) ? 32'h0 :
          32'(32'h0000_4005 + 32'(k * 8)) >> 3);
        k++;
      end
    end
    check("drained", 32'(k), 32'(tip_pkg::FIFO_DEPTH));
    check("empty ready", {31'h0, ardy}, 32'h0000_0001);
    $display("test data done");
  endtask
  // macrocell powered down: interface valid must stay low
  task automatic test_pwrdn();
    pwrdn = 1;
    repeat (3) tick();
    iv = 1;
    tick();
    iv = 0;
    check("pwrdn valid", {31'h0, ictl[0]}, 32'h0000_0000);
    pwrdn = 0;
    repeat (4) tick();
    $display("test pwrdn done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1 rst_n = 1;
    repeat (4) tick();
    test_instr();
    test_phantom();
    test_exc();
    test_data();
    test_pwrdn();
    end_of_test();
  end
  // the tests take some 145 cycles; a hang is cut after 2500
  initial begin
    #100000;
    bad_count++;
    end_of_test();
  end
endmodule
